// ---- verilog/csc_pkg.sv ----
// Purpose: Shared constants for the clock source configuration block
// Assumes: 8-bit register port, 10 MHz system clock
// Notes: Error input of the trim engine is in units of 0.1 percent
package csc_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_TIMER_CLOCK_CONFIG = 8'h31;
  localparam logic [7:0] ADDR_CLOCK_PAD_CONFIG = 8'h32;
  localparam logic [7:0] ADDR_USB_OSC_LOCK_CONFIG = 8'h39;
  localparam logic [7:0] ADDR_CLOCK_STATUS = 8'h3A;
  localparam logic [7:0] ADDR_TRIM_VALUE = 8'h3B;

  // Reset values
  localparam logic [7:0] RST_TIMER_CLOCK_CONFIG = 8'h8F;
  localparam logic [4:0] RST_CLOCK_PAD_CONFIG = 5'h00;
  localparam logic [1:0] RST_USB_OSC_LOCK_CONFIG = 2'h0;

  // timer_clock_config fields
  localparam int CAP_DIV_LSB = 6;
  localparam int CAP_SEL_LSB = 4;
  localparam int INT_DIV_LSB = 2;
  localparam int INT_SEL_LSB = 0;

  // clock_pad_config fields
  localparam int PAD_XTAL_SEL_BIT = 4;
  localparam int PAD_XTAL_ON_BIT = 3;
  localparam int PAD_FILT_BYPASS_BIT = 2;
  localparam int PAD_OUT_SEL_LSB = 0;

  // usb_osc_lock_config fields
  localparam int LOCK_COARSE_SKIP_BIT = 1;
  localparam int LOCK_TRIM_OFF_BIT = 0;

  // Clock source codes
  localparam logic [1:0] SRC_OSC24 = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] SRC_OSC32 = 2'h2;
  localparam logic [1:0] SRC_LAST = 2'h3;

  // Trim engine
  localparam logic [7:0] TRIM_TOL_TENTHS = 8'h0F;
  localparam logic [7:0] TRIM_COARSE_TH = 8'h28;
  localparam logic [7:0] TRIM_FINE_DB = 8'h02;
  localparam logic [2:0] COARSE_MID = 3'h4;
  localparam logic [4:0] FINE_MID = 5'h10;

  // Timing
  localparam int CLK_KHZ = 10000;
  localparam int XTAL_START_MS = 2;
  localparam int XTAL_START_CYC = XTAL_START_MS * CLK_KHZ;
  localparam logic [1:0] FILT_CYC = 2'h3;
endpackage

// ---- verilog/csc_trim_if.sv ----
// Purpose: Carrier between configuration logic and oscillator trim engine
// Assumes: Single clock domain
// Notes: Error is signed, positive means oscillator runs slow
`timescale 1ns/100ps
`default_nettype none
interface csc_trim_if;
  logic enable;
  logic coarse_skip;
  logic pkt_valid;
  logic [7:0] pkt_err;
  logic [2:0] coarse;
  logic [4:0] fine;
  logic locked;
  modport ctl (output enable, output coarse_skip, output pkt_valid, output pkt_err,
               input coarse, input fine, input locked);
  modport eng (input enable, input coarse_skip, input pkt_valid, input pkt_err,
               output coarse, output fine, output locked);
endinterface
`default_nettype wire

// ---- verilog/csc_osc_trim.sv ----
// Purpose: Coarse and fine trim of the internal 24 MHz oscillator
// Assumes: One measurement pulse per received USB packet
// Notes: Trim values saturate at their ends
`timescale 1ns/100ps
`default_nettype none
module csc_osc_trim (
  input wire logic i_clk,     // System clock
  input wire logic i_rst_b,   // Synchronous reset, active low
  csc_trim_if.eng trim        // Trim request and result
);
  logic [7:0] mag;
  logic fast;

  assign fast = trim.pkt_err[7];
  assign mag = fast ? 8'(~trim.pkt_err + 8'h01) : trim.pkt_err;

  // Steps only on packets while trimming is allowed
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      trim.coarse <= csc_pkg::COARSE_MID;
      trim.fine <= csc_pkg::FINE_MID;
    end else if (trim.enable && trim.pkt_valid) begin
      if (!trim.coarse_skip && mag > csc_pkg::TRIM_COARSE_TH) begin
        trim.fine <= csc_pkg::FINE_MID;
        if (!fast && trim.coarse != 3'h7) begin
          trim.coarse <= trim.coarse + 3'h1;
        end else if (fast && trim.coarse != 3'h0) begin
          trim.coarse <= trim.coarse - 3'h1;
        end
      end else if (mag > csc_pkg::TRIM_FINE_DB) begin
        if (!fast && trim.fine != 5'h1F) begin
          trim.fine <= trim.fine + 5'h01;
        end else if (fast && trim.fine != 5'h00) begin
          trim.fine <= trim.fine - 5'h01;
        end
      end
    end
  end

  // Lock flag follows the last measured error against the tolerance
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      trim.locked <= 1'b0;
    end else if (!trim.enable) begin
      trim.locked <= 1'b0;
    end else if (trim.pkt_valid) begin
      trim.locked <= (mag <= csc_pkg::TRIM_TOL_TENTHS);
    end
  end
endmodule
`default_nettype wire

// ---- verilog/csc_clock_source_config.sv ----
// Purpose: Clock source, divider, pad and oscillator trim configuration
// Assumes: Source ticks are one-cycle pulses on i_clk; pad levels are asynchronous
// Notes: Generated timer clocks are one-cycle enable pulses
`timescale 1ns/100ps
`default_nettype none
module csc_clock_source_config #(
  parameter int P_XTAL_START_CYC = csc_pkg::XTAL_START_CYC
) (
  input wire logic i_clk,                    // System clock, 10 MHz
  input wire logic i_rst_b,                  // Synchronous reset, active low
  input wire logic [7:0] i_addr,             // Register address
  input wire logic [7:0] i_wdata,            // Register write data
  input wire logic i_wr,                     // Write strobe
  input wire logic i_rd,                     // Read strobe
  output logic [7:0] o_rdata,                // Read data, cycle after i_rd
  input wire logic i_osc24_tick,             // Internal 24 MHz oscillator tick
  input wire logic i_osc32_tick,             // Internal 32 kHz oscillator tick
  input wire logic i_cpu_core_clock_tick,    // CPU clock tick
  input wire logic i_xtal_clk,               // Crystal oscillator block output level
  input wire logic i_port0_pin0_in,          // Pin0 GPIO input level
  input wire logic i_port0_pin0_oe,          // Pin0 GPIO output enable request
  input wire logic i_port0_pin1_oe,          // Pin1 GPIO output enable request
  input wire logic i_usb_clk_internal,       // USB engine clocked by internal osc
  input wire logic i_usb_pkt_valid,          // Packet timing measurement ready
  input wire logic [7:0] i_usb_pkt_err,      // Signed frequency error, 0.1 percent
  output logic o_crystal_osc_on,             // Crystal oscillator enable
  output logic o_port0_pin0_oe,              // Pin0 output enable to pad
  output logic o_port0_pin1_oe,              // Pin1 output enable to pad
  output logic o_clock_out_pad,              // Clock output pad level
  output logic o_interval_timer_clock,       // Interval timer clock tick
  output logic o_capture_timer_clock,        // Capture timer clock tick
  output logic [2:0] o_osc_coarse_trim,      // Oscillator coarse trim
  output logic [4:0] o_osc_fine_trim         // Oscillator fine trim
);
  logic [7:0] timer_cfg_q;
  logic [4:0] pad_cfg_q;
  logic [1:0] lock_cfg_q;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] sync3_q;
  logic [1:0] lvl_q;
  logic filt_lvl_q;
  logic [1:0] filt_cnt_q;
  logic clk_in_q;
  logic ext_q;
  logic ext_prev_q;
  logic ext_tick;
  logic clk_in_raw;
  logic ext_raw;
  logic [2:0] cap_cnt_q;
  logic [1:0] int_cnt_q;
  logic cap_src_tick;
  logic int_src_tick;
  logic [2:0] cap_limit;
  logic [1:0] cap_sel;
  logic [1:0] int_sel;
  logic [1:0] out_sel;
  logic [14:0] start_cnt_q;
  logic start_done_q;
  logic [7:0] rdata_d;
  logic xtal_on;
  logic xtal_sel;

  csc_trim_if trim ();

  csc_osc_trim u_trim (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .trim(trim)
  );

  assign xtal_on = pad_cfg_q[csc_pkg::PAD_XTAL_ON_BIT];
  assign xtal_sel = pad_cfg_q[csc_pkg::PAD_XTAL_SEL_BIT];
  assign cap_sel = timer_cfg_q[csc_pkg::CAP_SEL_LSB +: 2];
  assign int_sel = timer_cfg_q[csc_pkg::INT_SEL_LSB +: 2];
  assign out_sel = pad_cfg_q[csc_pkg::PAD_OUT_SEL_LSB +: 2];

  // Register writes
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      timer_cfg_q <= csc_pkg::RST_TIMER_CLOCK_CONFIG;
      pad_cfg_q <= csc_pkg::RST_CLOCK_PAD_CONFIG;
      lock_cfg_q <= csc_pkg::RST_USB_OSC_LOCK_CONFIG;
    end else if (i_wr) begin
      if (i_addr == csc_pkg::ADDR_TIMER_CLOCK_CONFIG) begin
        timer_cfg_q <= i_wdata;
      end else if (i_addr == csc_pkg::ADDR_CLOCK_PAD_CONFIG) begin
        pad_cfg_q <= i_wdata[4:0];
      end else if (i_addr == csc_pkg::ADDR_USB_OSC_LOCK_CONFIG) begin
        lock_cfg_q <= i_wdata[1:0];
      end
    end
  end

  // Read decode, reserved bits and unmapped addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    if (i_addr == csc_pkg::ADDR_TIMER_CLOCK_CONFIG) begin
      rdata_d = timer_cfg_q;
    end else if (i_addr == csc_pkg::ADDR_CLOCK_PAD_CONFIG) begin
      rdata_d = {3'h0, pad_cfg_q};
    end else if (i_addr == csc_pkg::ADDR_USB_OSC_LOCK_CONFIG) begin
      rdata_d = {6'h00, lock_cfg_q};
    end else if (i_addr == csc_pkg::ADDR_CLOCK_STATUS) begin
      rdata_d = {4'h0, ext_q, trim.enable, start_done_q, trim.locked};
    end else if (i_addr == csc_pkg::ADDR_TRIM_VALUE) begin
      rdata_d = {trim.coarse, trim.fine};
    end
  end

  // Read data stands one cycle, then returns to zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rdata_d;
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // Trim engine control
  assign trim.enable = !lock_cfg_q[csc_pkg::LOCK_TRIM_OFF_BIT] && i_usb_clk_internal;
  assign trim.coarse_skip = lock_cfg_q[csc_pkg::LOCK_COARSE_SKIP_BIT];
  assign trim.pkt_valid = i_usb_pkt_valid;
  assign trim.pkt_err = i_usb_pkt_err;
  assign o_osc_coarse_trim = trim.coarse;
  assign o_osc_fine_trim = trim.fine;

  // Pad level synchronisers: bit 0 crystal, bit 1 pin0
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
      sync3_q <= 2'h0;
    end else begin
      sync1_q <= {i_port0_pin0_in, i_xtal_clk};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // A pad change counts once the second and third stages agree
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      lvl_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          lvl_q[i] <= sync3_q[i];
        end
      end
    end
  end

  assign clk_in_raw = xtal_on ? lvl_q[0] : lvl_q[1];

  // Transient filter: a new level must hold for several cycles
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      filt_lvl_q <= 1'b0;
      filt_cnt_q <= 2'h0;
    end else if (clk_in_raw == filt_lvl_q) begin
      filt_cnt_q <= 2'h0;
    end else if (filt_cnt_q == csc_pkg::FILT_CYC - 2'h1) begin
      filt_lvl_q <= clk_in_raw;
      filt_cnt_q <= 2'h0;
    end else begin
      filt_cnt_q <= filt_cnt_q + 2'h1;
    end
  end

  // The crystal select path skips the filter
  assign ext_raw = xtal_sel ? lvl_q[0] : clk_in_q;
  assign ext_tick = ext_q && !ext_prev_q;

  // Input clock after the optional filter
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      clk_in_q <= 1'b0;
    end else begin
      clk_in_q <= pad_cfg_q[csc_pkg::PAD_FILT_BYPASS_BIT] ? clk_in_raw : filt_lvl_q;
    end
  end

  // External clock level and its history for edge detection
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ext_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_q <= ext_raw;
      ext_prev_q <= ext_q;
    end
  end

  // GPIO drivers on the shared pads are cut while the crystal runs
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_crystal_osc_on <= 1'b0;
      o_port0_pin0_oe <= 1'b0;
      o_port0_pin1_oe <= 1'b0;
    end else begin
      o_crystal_osc_on <= xtal_on;
      o_port0_pin0_oe <= i_port0_pin0_oe && !xtal_on;
      o_port0_pin1_oe <= i_port0_pin1_oe && !xtal_on;
    end
  end

  // Startup timer, status only; software still owns the wait
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || !xtal_on) begin
      start_cnt_q <= 15'h0000;
      start_done_q <= 1'b0;
    end else if (start_cnt_q == 15'(P_XTAL_START_CYC - 1)) begin
      start_done_q <= 1'b1;
    end else begin
      start_cnt_q <= start_cnt_q + 15'h0001;
    end
  end

  // Capture clock source and divider
  always_comb begin
    case (cap_sel)
      csc_pkg::SRC_OSC24: cap_src_tick = i_osc24_tick;
      csc_pkg::SRC_EXT: cap_src_tick = ext_tick;
      csc_pkg::SRC_OSC32: cap_src_tick = i_osc32_tick;
      default: cap_src_tick = 1'b0;
    endcase
  end

  // Division by 2, 4, 6, 8 gives a terminal count of 1, 3, 5, 7
  assign cap_limit = {timer_cfg_q[csc_pkg::CAP_DIV_LSB +: 2], 1'b1};

  always_ff @(posedge i_clk) begin
    if (!i_rst_b || cap_sel == csc_pkg::SRC_LAST) begin
      cap_cnt_q <= 3'h0;
      o_capture_timer_clock <= 1'b0;
    end else if (cap_src_tick) begin
      if (cap_cnt_q >= cap_limit) begin
        cap_cnt_q <= 3'h0;
        o_capture_timer_clock <= 1'b1;
      end else begin
        cap_cnt_q <= cap_cnt_q + 3'h1;
        o_capture_timer_clock <= 1'b0;
      end
    end else begin
      o_capture_timer_clock <= 1'b0;
    end
  end

  // Interval clock source and divider
  always_comb begin
    case (int_sel)
      csc_pkg::SRC_OSC24: int_src_tick = i_osc24_tick;
      csc_pkg::SRC_EXT: int_src_tick = ext_tick;
      csc_pkg::SRC_OSC32: int_src_tick = i_osc32_tick;
      default: int_src_tick = o_capture_timer_clock;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      int_cnt_q <= 2'h0;
      o_interval_timer_clock <= 1'b0;
    end else if (int_src_tick) begin
      if (int_cnt_q >= timer_cfg_q[csc_pkg::INT_DIV_LSB +: 2]) begin
        int_cnt_q <= 2'h0;
        o_interval_timer_clock <= 1'b1;
      end else begin
        int_cnt_q <= int_cnt_q + 2'h1;
        o_interval_timer_clock <= 1'b0;
      end
    end else begin
      o_interval_timer_clock <= 1'b0;
    end
  end

  // Clock output pad: tick sources toggle, external level is followed
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_clock_out_pad <= 1'b0;
    end else begin
      case (out_sel)
        csc_pkg::SRC_OSC24: o_clock_out_pad <= o_clock_out_pad ^ i_osc24_tick;
        csc_pkg::SRC_EXT: o_clock_out_pad <= ext_q;
        csc_pkg::SRC_OSC32: o_clock_out_pad <= o_clock_out_pad ^ i_osc32_tick;
        default: o_clock_out_pad <= o_clock_out_pad ^ i_cpu_core_clock_tick;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- dv/csc_clock_source_config_assertions.sv ----
// Purpose: Port-level checks of the clock source configuration block
// Assumes: Register mirrors track writes exactly as the block does
// Notes: Bound to every instance of the top module
`timescale 1ns/100ps
`default_nettype none
module csc_sva (
  input wire logic i_clk, // System clock
  input wire logic i_rst_b, // Synchronous reset, active low
  input wire logic i_wr, i_rd, i_osc24_tick, i_usb_clk_internal, i_usb_pkt_valid, // Inputs
  input wire logic [7:0] i_addr, i_wdata, i_usb_pkt_err, o_rdata, // Bus and trim error
  input wire logic o_crystal_osc_on, o_port0_pin0_oe, o_port0_pin1_oe, // Pad control
  input wire logic o_clock_out_pad, o_capture_timer_clock, // Generated clocks
  input wire logic [2:0] o_osc_coarse_trim, // Coarse trim
  input wire logic [4:0] o_osc_fine_trim // Fine trim
);
  logic [7:0] tcc_q, pad_q;
  logic [1:0] lock_q;
  logic en, big, up;
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      tcc_q <= csc_pkg::RST_TIMER_CLOCK_CONFIG;
      pad_q <= 8'h00;
      lock_q <= 2'h0;
    end else if (i_wr) begin
      if (i_addr == csc_pkg::ADDR_TIMER_CLOCK_CONFIG) tcc_q <= i_wdata;
      if (i_addr == csc_pkg::ADDR_CLOCK_PAD_CONFIG) pad_q <= i_wdata;
      if (i_addr == csc_pkg::ADDR_USB_OSC_LOCK_CONFIG) lock_q <= i_wdata[1:0];
    end
  end
  assign en = i_usb_pkt_valid && !lock_q[0] && i_usb_clk_internal;
  assign big = !i_usb_pkt_err[7] && i_usb_pkt_err > csc_pkg::TRIM_COARSE_TH;
  assign up = !i_usb_pkt_err[7] && i_usb_pkt_err > csc_pkg::TRIM_FINE_DB;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  sequence s_wr_tcc;
    i_wr && i_addr == csc_pkg::ADDR_TIMER_CLOCK_CONFIG;
  endsequence
  sequence s_rd_tcc;
    i_rd && i_addr == csc_pkg::ADDR_TIMER_CLOCK_CONFIG;
  endsequence
  AST_TCC_READBACK: assert property (
    s_wr_tcc ##1 !i_wr ##1 s_rd_tcc |=> o_rdata == $past(i_wdata, 3))
    else $error("timer clock config readback differs");
  AST_PAD_DRIVERS_OFF: assert property (
    o_crystal_osc_on |-> !o_port0_pin0_oe && !o_port0_pin1_oe)
    else $error("pad driver enabled while crystal on");
  AST_XTAL_FOLLOWS: assert property (o_crystal_osc_on == $past(pad_q[3]))
    else $error("crystal enable differs from written bit");
  AST_TRIM_OFF: assert property (
    i_usb_pkt_valid && lock_q[0] |=> $stable(o_osc_coarse_trim) && $stable(o_osc_fine_trim))
    else $error("trim moved while disabled");
  AST_TRIM_USB: assert property (
    i_usb_pkt_valid && !i_usb_clk_internal |=> $stable({o_osc_coarse_trim, o_osc_fine_trim}))
    else $error("trim moved without internal usb clock");
  AST_FINE_ONLY: assert property (en && lock_q[1] |=> $stable(o_osc_coarse_trim))
    else $error("coarse trim moved in fine-only mode");
  AST_COARSE_STEP: assert property (
    en && !lock_q[1] && big && o_osc_coarse_trim != 3'h7 |=>
    o_osc_coarse_trim == $past(o_osc_coarse_trim) + 3'h1 && o_osc_fine_trim == csc_pkg::FINE_MID)
    else $error("coarse step missing");
  AST_FINE_STEP: assert property (
    en && up && (lock_q[1] || !big) && o_osc_fine_trim != 5'h1F |=>
    o_osc_fine_trim == $past(o_osc_fine_trim) + 5'h01)
    else $error("fine step missing");
  AST_OUT_OSC24: assert property (
    pad_q[1:0] == csc_pkg::SRC_OSC24 && i_osc24_tick |=> o_clock_out_pad != $past(o_clock_out_pad))
    else $error("clock out did not toggle on oscillator tick");
  AST_CAPTURE_OFF: assert property (
    (tcc_q[5:4] == csc_pkg::SRC_LAST) [*2] |-> !o_capture_timer_clock)
    else $error("capture clock ticks while disabled");
endmodule
bind csc_clock_source_config csc_sva u_csc_sva (.i_clk, .i_rst_b, .i_wr, .i_rd, .i_osc24_tick,
  .i_usb_clk_internal, .i_usb_pkt_valid, .i_addr, .i_wdata, .i_usb_pkt_err, .o_rdata,
  .o_crystal_osc_on, .o_port0_pin0_oe, .o_port0_pin1_oe, .o_clock_out_pad,
  .o_capture_timer_clock, .o_osc_coarse_trim, .o_osc_fine_trim);
`default_nettype wire

// ---- dv/csc_xtal_model.sv ----
// Purpose: External crystal and pad clock source
// Assumes: Crystal output stays low while disabled or starting
// Notes: Pad signal runs free, as an outside clock would
`timescale 1ns/100ps
`default_nettype none
module csc_xtal_model #(
  parameter int P_START = 20, // Startup cycles before oscillation
  parameter int P_HALF = 3, // Crystal half period in system clocks
  parameter int P_PIN_HALF = 7 // Pad clock half period in system clocks
) (
  input wire logic i_clk, // System clock
  input wire logic i_on, // Crystal enable from the block
  output logic o_xtal_clk, // Crystal block output
  output logic o_pin_clk // Signal on the clock input pad
);
  int start = 0;
  int ph = 0;
  int pc = 0;
  initial o_xtal_clk = 1'b0;
  initial o_pin_clk = 1'b0;
  always @(posedge i_clk) begin
    pc <= (pc == P_PIN_HALF - 1) ? 0 : pc + 1;
    if (pc == P_PIN_HALF - 1) o_pin_clk <= ~o_pin_clk;
    if (!i_on) begin
      start <= 0;
      o_xtal_clk <= 1'b0;
    end else if (start < P_START) begin
      start <= start + 1;
    end else begin
      ph <= (ph == P_HALF - 1) ? 0 : ph + 1;
      if (ph == P_HALF - 1) o_xtal_clk <= ~o_xtal_clk;
    end
  end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for the clock source configuration block
// Assumes: Ticks come from the bench, crystal and pad clock from the model
// Notes: Edge counts allow one of slack at window ends
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0, usb_int = 1'b1, oe_req = 1'b1;
  logic tk24 = 1'b0, tk32 = 1'b0, tkcpu = 1'b0, pkt = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, err = 8'h00;
  logic xtal_clk, pin_clk, osc_on, oe0, oe1, clk_out, itc, ctc;
  logic [7:0] rdata, n_cap, n_int, n_tog;
  logic [2:0] coarse;
  logic [4:0] fine;
  int cyc = 0, n_errors = 0, checked = 0;
  csc_clock_source_config #(.P_XTAL_START_CYC(20)) DUT (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(rdata), .i_osc24_tick(tk24), .i_osc32_tick(tk32),
    .i_cpu_core_clock_tick(tkcpu), .i_xtal_clk(xtal_clk), .i_port0_pin0_in(pin_clk),
    .i_port0_pin0_oe(oe_req), .i_port0_pin1_oe(oe_req), .i_usb_clk_internal(usb_int),
    .i_usb_pkt_valid(pkt), .i_usb_pkt_err(err), .o_crystal_osc_on(osc_on),
    .o_port0_pin0_oe(oe0), .o_port0_pin1_oe(oe1), .o_clock_out_pad(clk_out),
    .o_interval_timer_clock(itc), .o_capture_timer_clock(ctc), .o_osc_coarse_trim(coarse),
    .o_osc_fine_trim(fine));
  csc_xtal_model #(.P_START(20)) u_xtal (.i_clk(i_clk), .i_on(osc_on), .o_xtal_clk(xtal_clk),
    .o_pin_clk(pin_clk));
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    tk24 <= (cyc % 2 == 0);
    tk32 <= (cyc % 5 == 0);
    tkcpu <= (cyc % 3 == 0);
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s,
                     input logic [7:0] g);
    checked++;
    if (((g >= e - s) && (g <= e + s)) !== 1'b1) begin
      n_errors++;
      $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk("rdata", e, 8'h00, rdata);
  endtask
  task automatic measure(input int n);
    logic prev;
    repeat (8) @(posedge i_clk);
    #1;
    prev = clk_out;
    n_cap = 8'h00;
    n_int = 8'h00;
    n_tog = 8'h00;
    repeat (n) begin
      @(posedge i_clk);
      #1;
      n_cap = n_cap + {7'h00, ctc};
      n_int = n_int + {7'h00, itc};
      n_tog = n_tog + {7'h00, clk_out ^ prev};
      prev = clk_out;
    end
  endtask
  task automatic t_regs;
    rd(csc_pkg::ADDR_TIMER_CLOCK_CONFIG, 8'h8F);
    rd(csc_pkg::ADDR_CLOCK_PAD_CONFIG, 8'h00);
    rd(csc_pkg::ADDR_USB_OSC_LOCK_CONFIG, 8'h00);
    rd(8'h40, 8'h00);
    wr(csc_pkg::ADDR_CLOCK_PAD_CONFIG, 8'hE7);
    rd(csc_pkg::ADDR_CLOCK_PAD_CONFIG, 8'h07);
    wr(csc_pkg::ADDR_TIMER_CLOCK_CONFIG, 8'h5A);
    rd(csc_pkg::ADDR_TIMER_CLOCK_CONFIG, 8'h5A);
  endtask
  task automatic t_xtal;
    wr(csc_pkg::ADDR_CLOCK_PAD_CONFIG, 8'h01);
    measure(84);
    chk("pad clock toggles", 8'h0C, 8'h01, n_tog);
    wr(csc_pkg::ADDR_CLOCK_PAD_CONFIG, 8'h09);
    @(posedge i_clk);
    #1;
    chk("pad drivers", 8'h01, 8'h00, {6'h00, oe0 | oe1, osc_on});
    repeat (40) @(posedge i_clk);
    measure(84);
    chk("crystal toggles", 8'h1C, 8'h01, n_tog);
    wr(csc_pkg::ADDR_CLOCK_PAD_CONFIG, 8'h19);
    measure(84);
    chk("selected crystal toggles", 8'h1C, 8'h01, n_tog);
    wr(csc_pkg::ADDR_CLOCK_PAD_CONFIG, 8'h09);
    wr(csc_pkg::ADDR_CLOCK_PAD_CONFIG, 8'h01);
    @(posedge i_clk);
    #1;
    chk("pad drivers", 8'h02, 8'h00, {6'h00, oe0 & oe1, osc_on});
    measure(84);
    chk("pad clock after crystal", 8'h0C, 8'h01, n_tog);
  endtask
  task automatic t_out;
    logic [9:0] row [3] = '{10'h01E, 10'h20C, 10'h314};
    for (int k = 0; k < 3; k++) begin
      wr(csc_pkg::ADDR_CLOCK_PAD_CONFIG, {6'h00, row[k][9:8]});
      measure(60);
      chk("clock out toggles", row[k][7:0], 8'h01, n_tog);
    end
  endtask
  task automatic t_timers;
    logic [23:0] row [8] = '{24'h073C1E, 24'h471E0F, 24'h87140A, 24'hC70F08, 24'h370000,
                             24'h3E000C, 24'h201878, 24'h110911};
    for (int k = 0; k < 8; k++) begin
      wr(csc_pkg::ADDR_TIMER_CLOCK_CONFIG, row[k][23:16]);
      measure(240);
      chk("capture ticks", row[k][15:8], {7'h00, row[k][15:8] != 8'h00}, n_cap);
      chk("interval ticks", row[k][7:0], {7'h00, row[k][7:0] != 8'h00}, n_int);
    end
  endtask
  task automatic t_trim;
    logic [23:0] row [7] = '{24'h010591, 24'h0132B0, 24'h01CE90, 24'h213291, 24'h313291,
                             24'h003291, 24'h01FB90};
    for (int k = 0; k < 7; k++) begin
      wr(csc_pkg::ADDR_USB_OSC_LOCK_CONFIG, {4'h0, row[k][23:20]});
      usb_int <= row[k][16];
      err <= row[k][15:8];
      pkt <= 1'b1;
      @(posedge i_clk);
      pkt <= 1'b0;
      @(posedge i_clk);
      #1;
      chk("trim value", row[k][7:0], 8'h00, {coarse, fine});
    end
    rd(csc_pkg::ADDR_TRIM_VALUE, 8'h90);
  endtask
  task automatic stop_test;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_regs;
    t_xtal;
    t_out;
    t_timers;
    t_trim;
    stop_test;
  end
  initial begin
    #3000000;
    n_errors++;
    stop_test;
  end
endmodule
`default_nettype wire
